// ### hdl/mpr_bank_arb.sv
`timescale 1ns/10ps

module mpr_bank_arb
	import mpr_pkg::*;
#(
	parameter int N = 5
)
(
	input  wire logic         clk_i,   // clock
	input  wire logic         rst_i,   // synchronous reset
	input  wire logic [N-1:0] req_i,   // requests, index 0 highest
	input  wire logic         done_i,  // storage cycle ended
	output logic      [N-1:0] gnt_o,   // one-hot grant
	output logic              start_o, // first cycle of a grant
	output logic              busy_o   // bank held
);

	mpr_arb_e       state_r;
	logic [N-1:0]   pick;

	always_comb
	begin
		pick = '0;
		for (int i = N-1; i >= 0; i--)
		begin
			if (req_i[i])
			begin
				pick = '0;
				pick[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state_r <= MPR_ARB_IDLE;
		else
		begin
			case (state_r)
				MPR_ARB_IDLE: if (|req_i) state_r <= MPR_ARB_BUSY;
				MPR_ARB_BUSY: if (done_i) state_r <= MPR_ARB_IDLE;
				default:      state_r <= MPR_ARB_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			gnt_o <= '0;
		else if (state_r == MPR_ARB_IDLE)
			gnt_o <= pick;
		else if (done_i)
			gnt_o <= '0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			start_o <= 1'b0;
		else
			start_o <= (state_r == MPR_ARB_IDLE) && (|req_i);
	end

	assign busy_o = (state_r == MPR_ARB_BUSY);

	a_gnt_onehot: assert property (@(posedge clk_i) disable iff (rst_i) $onehot0(gnt_o))
		else $error("bank grant not one-hot");
	a_gnt_held: assert property (@(posedge clk_i) disable iff (rst_i)
		busy_o && !done_i |=> busy_o && $stable(gnt_o))
		else $error("grant changed inside a storage cycle");
	a_refresh_first: assert property (@(posedge clk_i) disable iff (rst_i)
		!busy_o && req_i[0] |=> gnt_o[0] && start_o)
		else $error("refresh not granted first");
	a_fixed_prio: assert property (@(posedge clk_i) disable iff (rst_i)
		!busy_o && !req_i[0] && req_i[1] && req_i[2] |=> gnt_o[1] && !gnt_o[2])
		else $error("fixed priority violated");
	c_contention: cover property (@(posedge clk_i) disable iff (rst_i) !busy_o && req_i[1] && req_i[2]);

endmodule // mpr_bank_arb

// ### hdl/mpr_consts.svh
`ifndef MPR_CONSTS_SVH
`define MPR_CONSTS_SVH

// Channel and bank address geometry.
`define MPR_ADDR_W       18
`define MPR_LOCAL_W      16
`define MPR_LIM_W        5
`define MPR_LIM_LSB      13
`define MPR_ROW_W        6

// Register byte offsets: one limit word per port, then mode and status.
`define MPR_OFS_LIM0     8'h00
`define MPR_OFS_LIM3     8'h0c
`define MPR_OFS_MODE     8'h10
`define MPR_OFS_STAT     8'h14

// Limit and status word fields, eight bits per limit.
`define MPR_LIM_LO0_LSB  0
`define MPR_LIM_UP0_LSB  8
`define MPR_LIM_LO1_LSB  16
`define MPR_LIM_UP1_LSB  24
`define MPR_STAT_ROW_LSB 8
`define MPR_STAT_PND_LSB 16

// Lower above upper leaves a bank unreachable until software maps it.
`define MPR_LIM_RST      32'h001f001f
`define MPR_MODE_RST     32'h00000000

// Refresh interval.
`define MPR_CLK_NS       5
`define MPR_REFRESH_NS   32000

`endif

// ### hdl/mpr_pkg.sv
package mpr_pkg;

	typedef enum logic [1:0]
	{
		MPR_ILV_NONE = 2'h0,
		MPR_ILV_17   = 2'h1,
		MPR_ILV_16   = 2'h2
	} mpr_ilv_e;

	typedef enum logic [1:0]
	{
		MPR_ARB_IDLE = 2'b01,
		MPR_ARB_BUSY = 2'b10
	} mpr_arb_e;

endpackage

// ### hdl/mpr_port_decode.sv
`timescale 1ns/10ps
`include "mpr_consts.svh"

module mpr_port_decode
	import mpr_pkg::*;
#(
	parameter int NB = 2
)
(
	input  wire logic [`MPR_ADDR_W-1:0]         addr_i,  // channel address
	input  wire logic [1:0]                     mode_i,  // interleave wiring
	input  wire logic [NB*`MPR_LIM_W-1:0]       lower_i, // lower limits per bank
	input  wire logic [NB*`MPR_LIM_W-1:0]       upper_i, // upper limits per bank
	output logic      [NB-1:0]                  hit_o,   // bank range hits
	output logic      [NB*`MPR_LOCAL_W-1:0]     local_o  // bank-local addresses
);

	logic [`MPR_ADDR_W-1:0] perm;

	always_comb
	begin
		case (mode_i)
			MPR_ILV_17: perm = {addr_i[0], addr_i[17:1]};
			MPR_ILV_16: perm = {addr_i[17], addr_i[0], addr_i[16:1]};
			default:    perm = addr_i;
		endcase
	end

	genvar b;
	generate
		for (b = 0; b < NB; b++)
		begin : g_bank
			logic [`MPR_LIM_W-1:0]  lo;
			logic [`MPR_LIM_W-1:0]  up;
			logic [`MPR_ADDR_W-1:0] diff;
			assign lo   = lower_i[b*`MPR_LIM_W +: `MPR_LIM_W];
			assign up   = upper_i[b*`MPR_LIM_W +: `MPR_LIM_W];
			// An empty range (lo above up) can never pass both compares.
			assign hit_o[b] = (perm[17:13] >= lo) && (perm[17:13] <= up);
			assign diff = perm - {lo, 13'h0};
			// Ranges wider than 64K alias; software must avoid them.
			assign local_o[b*`MPR_LOCAL_W +: `MPR_LOCAL_W] = diff[`MPR_LOCAL_W-1:0];
		end
	endgenerate

endmodule // mpr_port_decode

// ### hdl/mpr_router.sv
`timescale 1ns/10ps
`include "mpr_consts.svh"

// Function
// - Each bank spans 8K to 64K words, in 8K module steps, via limits.
// - Each port steers requests to a bank and forms its local address.
// - Every port reaches both banks; address range alone picks the bank.
// - Simultaneous requests to one bank are granted by fixed linear priority.
// - Channel addresses are 18 bits, reaching at most 256K words.
// - Only addresses inside a mapped range pass to the multiport memory.
// - Bits 0-12 address inside a module; bits 13-17 decode the bank.
// - Each port has per-bank lower and upper limits at 8K granularity.
// - All bank ranges are tested in parallel; a passing bank is selected.
// - Local address is channel address minus lower limit, 16 bits wide.
// - Lower limit above upper limit means that bank is never selected.
// - Limits are held per port, so views of a bank may differ.
// - Interleave moves address bit 0 to bit 17, others down one.
// - Bit 0 at 17 gives 128K bank offset; at 16 gives 64K.
// - A request to a busy bank waits until the current access ends.
// - Read has write low; data ready marks data valid after the access.
// - Refresh is the highest-priority requester and steps a 6-bit row counter.

module mpr_router
	import mpr_pkg::*;
#(
	parameter int NP             = 4,                                 // channel ports
	parameter int NB             = 2,                                 // banks per crate
	parameter int REFRESH_CYCLES = `MPR_REFRESH_NS / `MPR_CLK_NS      // refresh interval
)
(
	input  wire logic                      clk_i,        // clock, 200 MHz
	input  wire logic                      rst_i,        // synchronous reset
	input  wire logic [7:0]                wb_adr_i,     // Wishbone byte address
	input  wire logic [31:0]               wb_dat_i,     // Wishbone write data
	output logic      [31:0]               wb_dat_o,     // Wishbone read data
	input  wire logic                      wb_we_i,      // Wishbone write
	input  wire logic [3:0]                wb_sel_i,     // Wishbone byte lanes
	input  wire logic                      wb_cyc_i,     // Wishbone cycle
	input  wire logic                      wb_stb_i,     // Wishbone strobe
	output logic                           wb_ack_o,     // Wishbone acknowledge
	input  wire logic [NP-1:0]             ch_req_i,     // channel requests
	input  wire logic [NP-1:0]             ch_we_i,      // channel write, low for read
	input  wire logic [NP*`MPR_ADDR_W-1:0] ch_addr_i,    // channel addresses
	input  wire logic [NP*18-1:0]          ch_wdata_i,   // channel write data
	output logic      [NP-1:0]             ch_accept_o,  // address accepted pulse
	output logic      [NP-1:0]             ch_ack_o,     // data ready pulse
	output logic      [NP*18-1:0]          ch_rdata_o,   // channel read data
	output logic      [NB-1:0]             bank_cyc_o,   // storage cycle active
	output logic      [NB-1:0]             bank_we_o,    // storage write
	output logic      [NB-1:0]             bank_rfsh_o,  // storage cycle is refresh
	output logic      [NB*`MPR_LOCAL_W-1:0] bank_addr_o, // bank-local address
	output logic      [NB*18-1:0]          bank_wdata_o, // storage write data
	output logic      [`MPR_ROW_W-1:0]     bank_row_o,   // refresh row
	input  wire logic [NB-1:0]             bank_done_i,  // storage cycle ended
	input  wire logic [NB*18-1:0]          bank_rdata_i  // storage read data
);

	localparam int CW = $clog2(REFRESH_CYCLES + 1);
	localparam int NR = NP + 1;

	////////////////////////////////////////////////////////////////////////
	// Register file.

	logic [31:0]             lim_r [NP];
	logic [31:0]             mode_r;
	logic [31:0]             wmask;
	logic                    wb_hit;
	logic [NB-1:0]           pend_r;
	logic [`MPR_ROW_W-1:0]   row_r;
	logic [NB-1:0]           arb_busy;

	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_hit;
	end

	// Limits are kept per port so each channel can see its own map.
	genvar p;
	generate
		for (p = 0; p < NP; p++)
		begin : g_lim
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					lim_r[p] <= `MPR_LIM_RST;
				else if (wb_hit && wb_we_i && wb_adr_i == `MPR_OFS_LIM0 + 8'(4*p))
					lim_r[p] <= (lim_r[p] & ~wmask) | (wb_dat_i & wmask);
			end
		end
	endgenerate

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mode_r <= `MPR_MODE_RST;
		else if (wb_hit && wb_we_i && wb_adr_i == `MPR_OFS_MODE)
			mode_r <= (mode_r & ~wmask) | (wb_dat_i & wmask);
	end

	// Unmapped addresses are acknowledged and read as zero.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= '0;
		else if (wb_hit && !wb_we_i)
		begin
			if (wb_adr_i <= `MPR_OFS_LIM3 && wb_adr_i[1:0] == 2'h0)
				wb_dat_o <= lim_r[wb_adr_i[3:2]];
			else if (wb_adr_i == `MPR_OFS_MODE)
				wb_dat_o <= mode_r;
			else if (wb_adr_i == `MPR_OFS_STAT)
				wb_dat_o <= 32'(arb_busy) | (32'(row_r) << `MPR_STAT_ROW_LSB) | (32'(pend_r) << `MPR_STAT_PND_LSB);
			else
				wb_dat_o <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Port address decoding.

	logic [NB-1:0]             hit    [NP];
	logic [NB*`MPR_LOCAL_W-1:0] local_a [NP];
	logic [NP-1:0]             hit_any;
	logic [NP-1:0]             tgt;
	logic [NP-1:0]             served_r;
	logic [NP-1:0]             port_req;

	generate
		for (p = 0; p < NP; p++)
		begin : g_port
			mpr_port_decode #(
				.NB      (NB)
			) u_dec (
				.addr_i  (ch_addr_i[p*`MPR_ADDR_W +: `MPR_ADDR_W]),
				.mode_i  (mode_r[2*p +: 2]),
				.lower_i ({lim_r[p][`MPR_LIM_LO1_LSB +: `MPR_LIM_W], lim_r[p][`MPR_LIM_LO0_LSB +: `MPR_LIM_W]}),
				.upper_i ({lim_r[p][`MPR_LIM_UP1_LSB +: `MPR_LIM_W], lim_r[p][`MPR_LIM_UP0_LSB +: `MPR_LIM_W]}),
				.hit_o   (hit[p]),
				.local_o (local_a[p])
			);
			assign hit_any[p]  = |hit[p];
			// Bank 0 wins if software maps both banks over the same range.
			assign tgt[p]      = !hit[p][0];
			// A served port must drop its request before it may ask again.
			assign port_req[p] = ch_req_i[p] && !served_r[p] && hit_any[p];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Refresh timer and row counter.

	logic [CW-1:0] tick_cnt_r;
	logic          tick;

	assign tick = (tick_cnt_r == CW'(REFRESH_CYCLES - 1));

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			tick_cnt_r <= '0;
		else if (tick)
			tick_cnt_r <= '0;
		else
			tick_cnt_r <= tick_cnt_r + 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			row_r <= '0;
		else if (tick)
			row_r <= row_r + 1'b1;
	end

	assign bank_row_o = row_r;

	////////////////////////////////////////////////////////////////////////
	// Banks: arbitration and storage cycle.

	logic [NR-1:0] gnt   [NB];
	logic [NB-1:0] start;
	logic [NB-1:0] done;

	genvar b;
	generate
		for (b = 0; b < NB; b++)
		begin : g_bank
			logic [NR-1:0] req;

			for (p = 0; p < NP; p++)
			begin : g_req
				assign req[p+1] = port_req[p] && (tgt[p] == 1'(b));
			end
			assign req[0]  = pend_r[b];
			assign done[b] = bank_done_i[b] && bank_cyc_o[b];

			mpr_bank_arb #(
				.N       (NR)
			) u_arb (
				.clk_i   (clk_i),
				.rst_i   (rst_i),
				.req_i   (req),
				.done_i  (done[b]),
				.gnt_o   (gnt[b]),
				.start_o (start[b]),
				.busy_o  (arb_busy[b])
			);

			// A new tick wins over the clear of the refresh just finished.
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					pend_r[b] <= 1'b0;
				else if (tick)
					pend_r[b] <= 1'b1;
				else if (done[b] && bank_rfsh_o[b])
					pend_r[b] <= 1'b0;
			end

			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					bank_cyc_o[b] <= 1'b0;
				else if (start[b])
					bank_cyc_o[b] <= 1'b1;
				else if (done[b])
					bank_cyc_o[b] <= 1'b0;
			end

			// The channel holds its request, so sampling one cycle after grant is safe.
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					bank_we_o[b]   <= 1'b0;
					bank_rfsh_o[b] <= 1'b0;
					bank_addr_o[b*`MPR_LOCAL_W +: `MPR_LOCAL_W] <= '0;
					bank_wdata_o[b*18 +: 18] <= '0;
				end
				else if (start[b])
				begin
					bank_we_o[b]   <= 1'b0;
					bank_rfsh_o[b] <= gnt[b][0];
					bank_addr_o[b*`MPR_LOCAL_W +: `MPR_LOCAL_W] <= '0;
					bank_wdata_o[b*18 +: 18] <= '0;
					for (int i = 0; i < NP; i++)
					begin
						if (gnt[b][i+1])
						begin
							bank_we_o[b] <= ch_we_i[i];
							bank_addr_o[b*`MPR_LOCAL_W +: `MPR_LOCAL_W] <= local_a[i][b*`MPR_LOCAL_W +: `MPR_LOCAL_W];
							bank_wdata_o[b*18 +: 18] <= ch_wdata_i[i*18 +: 18];
						end
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Channel answers.

	generate
		for (p = 0; p < NP; p++)
		begin : g_ans
			logic acc;
			logic fin;
			logic [17:0] rd;

			always_comb
			begin
				acc = 1'b0;
				fin = 1'b0;
				rd  = '0;
				for (int j = 0; j < NB; j++)
				begin
					if (gnt[j][p+1] && start[j])
						acc = 1'b1;
					if (gnt[j][p+1] && done[j])
					begin
						fin = 1'b1;
						rd  = bank_rdata_i[j*18 +: 18];
					end
				end
			end

			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					ch_accept_o[p] <= 1'b0;
					ch_ack_o[p]    <= 1'b0;
				end
				else
				begin
					ch_accept_o[p] <= acc;
					ch_ack_o[p]    <= fin;
				end
			end

			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					ch_rdata_o[p*18 +: 18] <= '0;
				else if (fin && !ch_we_i[p])
					ch_rdata_o[p*18 +: 18] <= rd;
			end

			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					served_r[p] <= 1'b0;
				else if (fin)
					served_r[p] <= 1'b1;
				else if (!ch_req_i[p])
					served_r[p] <= 1'b0;
			end

			a_ack_needs_hit: assert property (@(posedge clk_i) disable iff (rst_i)
				ch_req_i[p] && !hit_any[p] |=> !ch_accept_o[p])
				else $error("unmapped request was accepted");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Checks.

	a_row_step: assert property (@(posedge clk_i) disable iff (rst_i)
		tick |=> row_r == $past(row_r) + 6'h01 && pend_r == {NB{1'b1}})
		else $error("refresh tick did not step the row counter");
	a_empty_bank: assert property (@(posedge clk_i) disable iff (rst_i)
		lim_r[0][4:0] > lim_r[0][12:8] |-> !hit[0][0])
		else $error("empty range selected a bank");
	a_wb_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("bus ack held longer than one cycle");
	a_bank_addr: assert property (@(posedge clk_i) disable iff (rst_i)
		start[0] && gnt[0][1] |=> bank_addr_o[15:0] == 16'($past(local_a[0][15:0])))
		else $error("bank address not taken from port decoder");

	c_refresh: cover property (@(posedge clk_i) disable iff (rst_i) start[0] && gnt[0][0]);
	c_ack: cover property (@(posedge clk_i) disable iff (rst_i) ch_ack_o[0]);
	c_ilv: cover property (@(posedge clk_i) disable iff (rst_i) mode_r[1:0] == MPR_ILV_17 && ch_ack_o[0]);

endmodule // mpr_router

// ### testbench/mpr_bank_model.sv
`timescale 1ns/10ps

// Storage behind both banks. Between done pulses the read data toggles, so stale data is never mistaken for valid.
module mpr_bank_model
(
	input  wire logic        clk_i,   // clock
	input  wire logic        rst_i,   // synchronous reset
	input  wire logic [1:0]  cyc_i,   // storage cycle active
	input  wire logic [1:0]  we_i,    // storage write
	input  wire logic [31:0] addr_i,  // bank-local addresses
	input  wire logic [35:0] wdata_i, // storage write data
	input  wire logic        slow_i,  // long access delay
	output logic      [1:0]  done_o,  // storage cycle end pulse
	output logic      [35:0] rdata_o  // storage read data
);
	logic [17:0] mem [int];
	logic [2:0]  cnt [2];

	always @(posedge clk_i)
	begin
		for (int b = 0; b < 2; b++)
		begin
			rdata_o[b*18+:18] <= rst_i ? 18'h0 : ~rdata_o[b*18+:18];
			done_o[b]         <= 1'b0;
			if (rst_i || !cyc_i[b] || done_o[b])
				cnt[b] <= 3'h0;
			else if (cnt[b] == (slow_i ? 3'h5 : 3'h1))
			begin
				done_o[b] <= 1'b1;
				if (we_i[b])
					mem[b * 65536 + int'(addr_i[b*16+:16])] = wdata_i[b*18+:18];
				else if (mem.exists(b * 65536 + int'(addr_i[b*16+:16])))
					rdata_o[b*18+:18] <= mem[b * 65536 + int'(addr_i[b*16+:16])];
				else
					rdata_o[b*18+:18] <= 18'h0;
			end
			else
				cnt[b] <= cnt[b] + 3'h1;
		end
	end
endmodule // mpr_bank_model

// ### testbench/mpr_router_tb.sv
`timescale 1ns/10ps
`include "mpr_consts.svh"

module mpr_router_tb;
	logic        clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o, slow = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wsel = 4'hf;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, bank_addr_o;
	logic [3:0]  wb_sel_i = 4'hf, ch_req_i = 4'h0, ch_we_i = 4'h0, ch_accept_o, ch_ack_o;
	logic [71:0] ch_addr_i = 72'h0, ch_wdata_i = 72'h0, ch_rdata_o;
	logic [1:0]  bank_cyc_o, bank_we_o, bank_rfsh_o, bank_done_i, cyc_q = 2'h0;
	logic [35:0] bank_wdata_o, bank_rdata_i;
	logic [5:0]  bank_row_o, row_q;
	logic [31:0] seed = 32'h0ec653ba;
	logic [15:0] mon_addr;
	logic [4:0]  lo [4][2], up [4][2];
	logic [1:0]  mode [4];
	int          error_cnt = 0, samples_checked = 0, mon_bank, rf_n = 0;
	bit          row_ok = 0;
	longint      ack_t [4];

	always #2.5 clk_i = ~clk_i;

	mpr_router #(.REFRESH_CYCLES(50)) mpr_router_inst (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
		.wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .ch_req_i, .ch_we_i, .ch_addr_i, .ch_wdata_i, .ch_accept_o,
		.ch_ack_o, .ch_rdata_o, .bank_cyc_o, .bank_we_o, .bank_rfsh_o, .bank_addr_o, .bank_wdata_o, .bank_row_o,
		.bank_done_i, .bank_rdata_i);
	mpr_bank_model mpr_bank_model_inst (.clk_i, .rst_i, .cyc_i(bank_cyc_o), .we_i(bank_we_o), .addr_i(bank_addr_o),
		.wdata_i(bank_wdata_o), .slow_i(slow), .done_o(bank_done_i), .rdata_o(bank_rdata_i));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Channel address that the port's wiring turns into the wanted permuted address.
	function automatic logic [17:0] unperm(logic [17:0] p, logic [1:0] m);
		case (m)
			2'h1:    return {p[16:0], p[17]};
			2'h2:    return {p[17], p[15:0], p[16]};
			default: return p;
		endcase
	endfunction

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask

	task automatic stop_test();
		$display("Mismatches %0d, comparisons %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_sel_i <= wsel;
		wb_adr_i <= a;
		wb_dat_i <= d;
		for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++)
			@(posedge clk_i);
		chk("bus ack", 1, wb_ack_o);
		if (wb_ack_o !== 1'b1)
			stop_test();
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic ch(input int p, input logic w, input logic [17:0] a, input logic [17:0] d, input int lim,
		output logic [17:0] q, output bit ok);
		int n;
		bit seen = 1'b0;
		@(posedge clk_i);
		ch_req_i[p]          <= 1'b1;
		ch_we_i[p]           <= w;
		ch_addr_i[p*18+:18]  <= a;
		ch_wdata_i[p*18+:18] <= d;
		for (n = 0; n < lim && ch_ack_o[p] !== 1'b1; n++)
		begin
			@(posedge clk_i);
			if (ch_accept_o[p] === 1'b1)
				seen = 1'b1;
		end
		ok       = (ch_ack_o[p] === 1'b1);
		chk("address accepted", ok, seen);
		q        = ch_rdata_o[p*18+:18];
		ack_t[p] = $time;
		ch_req_i[p]          <= 1'b0;
		ch_addr_i[p*18+:18]  <= ~a;
		ch_wdata_i[p*18+:18] <= ~d;
	endtask

	// Write then read back one word; c picks the lowest, highest or a random word of the range.
	task automatic acc(input int p, input int b, input int c);
		logic [31:0] r;
		logic [17:0] pa, a, d, q;
		logic [15:0] l;
		bit          ok;
		r     = rnd();
		slow <= r[20];
		pa    = {5'(lo[p][b] + r[31:24] % (up[p][b] - lo[p][b] + 1)), r[12:0]};
		if (c == 1)
			pa = {lo[p][b], 13'h0};
		if (c == 2)
			pa = {up[p][b], 13'h1fff};
		a = unperm(pa, mode[p]);
		l = 16'(pa - {lo[p][b], 13'h0});
		d = 18'(rnd());
		ch(p, 1'b1, a, d, 200, q, ok);
		chk("write done", 1, ok);
		chk("bank", b, mon_bank);
		chk("local addr", l, mon_addr);
		ch(p, 1'b0, a, ~d, 200, q, ok);
		chk("read data", d, q);
		chk("read local", l, mon_addr);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_i)
	begin
		for (int b = 0; b < 2; b++)
			if (bank_cyc_o[b] && !cyc_q[b] && !bank_rfsh_o[b])
			begin
				mon_bank <= b;
				mon_addr <= bank_addr_o[b*16+:16];
			end
		if (bank_cyc_o[0] && !cyc_q[0] && bank_rfsh_o[0])
		begin
			if (row_ok)
				chk("refresh row", 6'(row_q + 6'h1), bank_row_o);
			row_q  <= bank_row_o;
			row_ok <= 1'b1;
			rf_n++;
		end
		cyc_q <= rst_i ? 2'h0 : bank_cyc_o;
	end

	initial
	begin
		logic [31:0] q;
		logic [17:0] q0, q1;
		bit          ok0, ok1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, `MPR_OFS_LIM0, 32'h0, q);
		chk("limit reset", `MPR_LIM_RST, q);
		wb(1'b0, `MPR_OFS_LIM3, 32'h0, q);
		chk("limit reset", `MPR_LIM_RST, q);
		wb(1'b0, `MPR_OFS_MODE, 32'h0, q);
		chk("mode reset", `MPR_MODE_RST, q);
		wb(1'b1, 8'h40, 32'hffffffff, q);
		wb(1'b0, 8'h40, 32'h0, q);
		chk("unmapped read", 0, q);
		// Only the two upper-limit lanes are enabled, so the lower limits must survive.
		wsel = 4'ha;
		wb(1'b1, `MPR_OFS_LIM0, 32'hffffffff, q);
		wsel = 4'hf;
		wb(1'b0, `MPR_OFS_LIM0, 32'h0, q);
		chk("lane mask", 32'hff1fff1f, q);
		lo[0] = '{5'h02, 5'h08};
		up[0] = '{5'h03, 5'h0b};
		lo[1] = '{5'h04, 5'h10};
		up[1] = '{5'h05, 5'h13};
		lo[2] = '{5'h1f, 5'h1f};
		up[2] = '{5'h00, 5'h00};
		lo[3] = '{5'h00, 5'h18};
		up[3] = '{5'h07, 5'h1f};
		for (int p = 0; p < 4; p++)
		begin
			wb(1'b1, 8'(4 * p), {3'h0, up[p][1], 3'h0, lo[p][1], 3'h0, up[p][0], 3'h0, lo[p][0]}, q);
			wb(1'b0, 8'(4 * p), 32'h0, q);
			chk("limit word", {3'h0, up[p][1], 3'h0, lo[p][1], 3'h0, up[p][0], 3'h0, lo[p][0]}, q);
		end
		for (int m = 0; m < 4; m++)
		begin
			mode[0] = 2'(m);
			mode[1] = 2'(m + 1);
			mode[2] = 2'h0;
			mode[3] = 2'(m + 2);
			wb(1'b1, `MPR_OFS_MODE, {24'h0, mode[3], mode[2], mode[1], mode[0]}, q);
			wb(1'b0, `MPR_OFS_MODE, 32'h0, q);
			chk("mode", {24'h0, mode[3], mode[2], mode[1], mode[0]}, q);
			for (int k = 0; k < 8; k++)
				acc((k % 3 == 2) ? 3 : k % 3, int'(rnd() & 32'h1), k % 4);
		end
		mode = '{2'h0, 2'h0, 2'h0, 2'h0};
		wb(1'b1, `MPR_OFS_MODE, 32'h0, q);
		slow <= 1'b1;
		fork
			ch(1, 1'b1, 18'h08123, 18'h2aaaa, 200, q1, ok1);
			ch(0, 1'b1, 18'h04321, 18'h15555, 200, q0, ok0);
		join
		chk("both served", 2, ok0 + ok1);
		chk("priority order", 1, ack_t[0] < ack_t[1]);
		ch(2, 1'b0, 18'(rnd()), 18'h0, 40, q0, ok0);
		chk("unmapped port", 0, ok0);
		repeat (150) @(posedge clk_i);
		chk("refresh seen", 1, rf_n > 2);
		stop_test();
	end
endmodule // mpr_router_tb
